/* setpoint_pkg.sv */
// Purpose: shared constants and types for the pressure setpoint switching block
// Assumes: 40 MHz mclk, pressure in 16-bit full-scale units
// Notes: holds the contract list
//
// Contract
// - low trip: closed while pressure below threshold
// - high trip: closed while pressure above threshold
// - reset or restore defaults to low trip
// - direction, hysteresis set only by register port; a setpoint press also resets hysteresis to default
// - any in-range threshold accepted
// - setpoint button: show threshold 10 s, blink; with no zero button use, adjustment exits after 5 s and ends the display
// - held zero button ramps threshold to limit
// - re-press held in 3-5 s reverses ramp
// - brief re-press in 0-3 s steps one unit
// - released over 5 s returns to measurement
// - default hysteresis one percent full scale
// - setpoint button restores default hysteresis
// - second channel uses same procedure
// - ambient relative mode with same options
// - ambient threshold is factor times atmosphere
// - channel may output gauge status instead
// - zero held 5 s at power-up restores
// - restore returns all user parameters to default
// - address switches sampled once at init
// - address is hundreds*0x100+tens*0x10+units
// - default explicit address is zero
// - indicator blinks while waiting, off when open
// - channels configured and evaluated independently
package setpoint_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned SHOW_MS = 10000;
  localparam int unsigned REVERSE_MIN_MS = 3000;
  localparam int unsigned IDLE_MAX_MS = 5000;
  localparam int unsigned RESTORE_MS = 5000;
  localparam int unsigned RAMP_STEP_MS = 10;
  localparam int unsigned BLINK_FAST_MS = 100;
  localparam int unsigned BLINK_MS = 250;
  localparam logic [15:0] FULL_SCALE = 16'hffff;
  localparam logic [15:0] HYST_DEFAULT = 16'h028f;
  localparam logic [15:0] THRESH_DEFAULT = 16'h0100;
  localparam logic [15:0] FACTOR_DEFAULT = 16'h0100;
  localparam logic [11:0] ADDR_DEFAULT = 12'h000;
  localparam logic [4:0] REG_CTRL0 = 5'h00;
  localparam logic [4:0] REG_THRESH0 = 5'h01;
  localparam logic [4:0] REG_HYST0 = 5'h02;
  localparam logic [4:0] REG_FACTOR0 = 5'h03;
  localparam logic [4:0] REG_CTRL1 = 5'h04;
  localparam logic [4:0] REG_THRESH1 = 5'h05;
  localparam logic [4:0] REG_HYST1 = 5'h06;
  localparam logic [4:0] REG_FACTOR1 = 5'h07;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_ADDR = 5'h09;
  localparam logic [4:0] REG_USER = 5'h0a;
  localparam int CTRL_HIGH_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  typedef enum logic [1:0] {
    MODE_VACUUM = 2'h0,
    MODE_AMBIENT = 2'h1,
    MODE_STATUS = 2'h2
  } chan_mode_t;
  typedef struct packed {
    logic high_trip;
    chan_mode_t mode;
    logic [15:0] thresh;
    logic [15:0] hyst;
    logic [15:0] factor;
  } chan_cfg_t;
  localparam chan_cfg_t CFG_DEFAULT = '{high_trip: 1'b0, mode: MODE_VACUUM,
    thresh: THRESH_DEFAULT, hyst: HYST_DEFAULT, factor: FACTOR_DEFAULT};
endpackage : setpoint_pkg

/* setpoint_compare.sv */
// Purpose: one setpoint channel comparator with hysteresis
// Assumes: sample_valid marks a new pressure sample
// Notes: factor is 8.8 fixed point
`timescale 1ns/1ps
`default_nettype none
module setpoint_compare
  import setpoint_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [15:0] pressure,
  input wire logic [15:0] atmosphere,
  input wire logic gauge_ok,
  input var chan_cfg_t cfg,
  output logic closed
);
  logic closed_reg;
  logic [31:0] prod;
  logic [16:0] trip;
  logic [16:0] rel;
  logic [16:0] p;
  always_comb begin
    prod = atmosphere * cfg.factor;
    trip = (cfg.mode == MODE_AMBIENT) ?
      ((prod[31:24] != 8'h00) ? {1'b0, FULL_SCALE} : {1'b0, prod[23:8]}) : {1'b0, cfg.thresh};
    p = {1'b0, pressure};
    rel = cfg.high_trip ? ((trip > {1'b0, cfg.hyst}) ? trip - {1'b0, cfg.hyst} : 17'h0)
                        : trip + {1'b0, cfg.hyst};
  end
  // hold the contact between crossings so noise near the threshold cannot chatter it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      closed_reg <= 1'b0;
    end else if (cfg.mode == MODE_STATUS) begin
      closed_reg <= gauge_ok;
    end else if (sample_valid) begin
      if (cfg.high_trip) begin
        if (p > trip) closed_reg <= 1'b1;
        else if (p < rel) closed_reg <= 1'b0;
      end else begin
        if (p < trip) closed_reg <= 1'b1;
        else if (p > rel) closed_reg <= 1'b0;
      end
    end
  end
  assign closed = closed_reg;
endmodule : setpoint_compare
`default_nettype wire

/* setpoint_switching.sv */
// Purpose: two setpoint channels, button adjustment, restore and address capture
// Assumes: all inputs synchronous to mclk; buttons active high when pressed
// Notes: register port reaches per-channel config, status and address
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module setpoint_switching
  import setpoint_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [15:0] pressure,
  input wire logic [15:0] atmosphere,
  input wire logic gauge_ok,
  input wire logic setpoint_button,
  input wire logic zero_button,
  input wire logic [3:0] address_switch_hundreds,
  input wire logic [3:0] address_switch_tens,
  input wire logic [3:0] address_switch_units,
  output logic [15:0] signal_out,
  output logic [1:0] contact_closed,
  output logic first_channel_indicator,
  output logic second_channel_indicator,
  output logic status_blink_fast,
  output logic restore_pulse,
  output logic [11:0] explicit_address
);
  // ***************************************************
  // time base and debouncing
  // ***************************************************
  logic [15:0] tick_cnt_reg;
  logic tick;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 16'h0;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h1;
    end
  end
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  logic [1:0] btn_raw;
  logic [1:0] btn_reg;
  logic [1:0] btn_prev_reg;
  logic [4:0] db_cnt_reg [2];
  assign btn_raw = {zero_button, setpoint_button};
  // any bounce restarts the count, so a press must hold the whole span
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_db
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          db_cnt_reg[gi] <= 5'h0;
          btn_reg[gi] <= 1'b0;
        end else if (btn_raw[gi] == btn_reg[gi]) begin
          db_cnt_reg[gi] <= 5'h0;
        end else if (tick) begin
          if (db_cnt_reg[gi] == 5'(DEBOUNCE_MS - 1)) begin
            btn_reg[gi] <= btn_raw[gi];
            db_cnt_reg[gi] <= 5'h0;
          end else begin
            db_cnt_reg[gi] <= db_cnt_reg[gi] + 5'h1;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      btn_prev_reg <= 2'b00;
    end else begin
      btn_prev_reg <= btn_reg;
    end
  end
  logic sp_press;
  logic zero_press;
  logic zero_release;
  assign sp_press = btn_reg[0] & ~btn_prev_reg[0];
  assign zero_press = btn_reg[1] & ~btn_prev_reg[1];
  assign zero_release = ~btn_reg[1] & btn_prev_reg[1];

  // ***************************************************
  // power-up: address capture and restore detection
  // ***************************************************
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_RUN = 4'b0100,
    ST_ADJ = 4'b1000
  } state_t;
  state_t state_reg;
  logic [13:0] ms_reg;
  logic [11:0] addr_reg;
  logic restore_reg;
  logic init_done_reg;
  // switches are read once; a changed address needs a new power-up
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= ADDR_DEFAULT;
      init_done_reg <= 1'b0;
    end else if (!init_done_reg) begin
      addr_reg <= {address_switch_hundreds, address_switch_tens, address_switch_units};
      init_done_reg <= 1'b1;
    end
  end
  assign explicit_address = addr_reg;

  // ***************************************************
  // configuration registers and adjustment state machine
  // ***************************************************
  chan_cfg_t cfg_reg [2];
  logic chan_reg;
  logic dir_down_reg;
  logic ramping_reg;
  logic fast_reg;
  logic [13:0] fast_ms_reg;
  logic [13:0] show_ms_reg;
  logic [3:0] step_ms_reg;
  logic [15:0] user_reg;
  logic [15:0] cur_thr;
  assign cur_thr = cfg_reg[chan_reg].thresh;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_INIT;
      ms_reg <= 14'h0;
      show_ms_reg <= 14'h0;
      step_ms_reg <= 4'h0;
      restore_reg <= 1'b0;
      chan_reg <= 1'b0;
      dir_down_reg <= 1'b0;
      ramping_reg <= 1'b0;
      fast_reg <= 1'b0;
      fast_ms_reg <= 14'h0;
      user_reg <= 16'h0;
      cfg_reg[0] <= CFG_DEFAULT;
      cfg_reg[1] <= CFG_DEFAULT;
    end else begin
      restore_reg <= 1'b0;
      // reversal feedback lasts a fixed span, then the normal rate returns
      if (tick && fast_ms_reg != 14'h0) begin
        fast_ms_reg <= fast_ms_reg - 14'h1;
      end else if (fast_ms_reg == 14'h0) begin
        fast_reg <= 1'b0;
      end
      // register port writes: the only path to direction and mode besides restore; hysteresis is also reset by a setpoint press
      if (reg_wr) begin
        if (reg_addr == REG_CTRL0 || reg_addr == REG_CTRL1) begin
          cfg_reg[reg_addr[2]].high_trip <= reg_wdata[CTRL_HIGH_BIT];
          cfg_reg[reg_addr[2]].mode <= chan_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
        end else if (reg_addr == REG_THRESH0 || reg_addr == REG_THRESH1) begin
          cfg_reg[reg_addr[2]].thresh <= reg_wdata;
        end else if (reg_addr == REG_HYST0 || reg_addr == REG_HYST1) begin
          cfg_reg[reg_addr[2]].hyst <= reg_wdata;
        end else if (reg_addr == REG_FACTOR0 || reg_addr == REG_FACTOR1) begin
          cfg_reg[reg_addr[2]].factor <= reg_wdata;
        end else if (reg_addr == REG_USER) begin
          user_reg <= reg_wdata;
        end
      end
      case (state_reg)
        ST_INIT: begin
          // raw level here: the debounced copy is not valid this early
          ms_reg <= 14'h0;
          state_reg <= btn_raw[1] ? ST_HOLD : ST_RUN;
        end
        ST_HOLD: begin
          if (!btn_reg[1] && !btn_raw[1]) begin
            state_reg <= ST_RUN;
          end else if (tick) begin
            if (ms_reg == 14'(RESTORE_MS - 1)) begin
              restore_reg <= 1'b1;
              cfg_reg[0] <= CFG_DEFAULT;
              cfg_reg[1] <= CFG_DEFAULT;
              user_reg <= 16'h0;
              state_reg <= ST_RUN;
            end else begin
              ms_reg <= ms_reg + 14'h1;
            end
          end
        end
        ST_RUN: begin
          if (sp_press) begin
            state_reg <= ST_ADJ;
            chan_reg <= 1'b0;
            cfg_reg[0].hyst <= HYST_DEFAULT;
            show_ms_reg <= 14'h0;
            ms_reg <= 14'h0;
            dir_down_reg <= 1'b0;
            ramping_reg <= 1'b0;
          end
        end
        ST_ADJ: begin
          // second press of the setpoint button moves on to the next channel
          if (sp_press) begin
            if (chan_reg) begin
              state_reg <= ST_RUN;
            end else begin
              chan_reg <= 1'b1;
              cfg_reg[1].hyst <= HYST_DEFAULT;
              show_ms_reg <= 14'h0;
              ms_reg <= 14'h0;
              ramping_reg <= 1'b0;
            end
          end else if (zero_press) begin
            ms_reg <= 14'h0;
            if (ms_reg >= 14'(REVERSE_MIN_MS) && ms_reg <= 14'(IDLE_MAX_MS)) begin
              dir_down_reg <= ~dir_down_reg;
              fast_reg <= 1'b1;
              fast_ms_reg <= 14'(REVERSE_MIN_MS);
            end
            ramping_reg <= 1'b0;
            step_ms_reg <= 4'h0;
          end else if (zero_release) begin
            // a short press that never reached ramp speed counts as one step
            if (!ramping_reg) begin
              if (dir_down_reg && cur_thr != 16'h0) cfg_reg[chan_reg].thresh <= cur_thr - 16'h1;
              else if (!dir_down_reg && cur_thr != FULL_SCALE) cfg_reg[chan_reg].thresh <= cur_thr + 16'h1;
            end
            ms_reg <= 14'h0;
            ramping_reg <= 1'b0;
          end else if (tick) begin
            if (show_ms_reg != 14'(SHOW_MS)) show_ms_reg <= show_ms_reg + 14'h1;
            // the ramp stops at the range ends rather than wrapping
            if (btn_reg[1]) begin
              if (step_ms_reg == 4'(RAMP_STEP_MS - 1)) begin
                step_ms_reg <= 4'h0;
                ramping_reg <= 1'b1;
                show_ms_reg <= 14'h0;
                if (dir_down_reg && cur_thr != 16'h0) cfg_reg[chan_reg].thresh <= cur_thr - 16'h1;
                else if (!dir_down_reg && cur_thr != FULL_SCALE) cfg_reg[chan_reg].thresh <= cur_thr + 16'h1;
              end else begin
                step_ms_reg <= step_ms_reg + 4'h1;
              end
            end else if (ms_reg == 14'(IDLE_MAX_MS)) begin
              state_reg <= ST_RUN;
            end else begin
              ms_reg <= ms_reg + 14'h1;
            end
          end
        end
        default: state_reg <= ST_INIT;
      endcase
    end
  end
  assign restore_pulse = restore_reg;
  assign status_blink_fast = fast_reg;

  // ***************************************************
  // channel comparators
  // ***************************************************
  logic [1:0] closed;
  // one sample strobe for both, each channel with its own configuration
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      setpoint_compare u_cmp (
        .mclk(mclk),
        .arst_n(arst_n),
        .sample_valid(sample_valid),
        .pressure(pressure),
        .atmosphere(atmosphere),
        .gauge_ok(gauge_ok),
        .cfg(cfg_reg[gi]),
        .closed(closed[gi])
      );
    end
  endgenerate
  assign contact_closed = closed;

  // ***************************************************
  // indicators and signal output
  // ***************************************************
  logic [7:0] blink_ms_reg;
  logic blink_reg;
  logic [15:0] sig_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      blink_ms_reg <= 8'h0;
      blink_reg <= 1'b0;
    end else if (tick) begin
      if (blink_ms_reg == 8'(BLINK_MS - 1)) begin
        blink_ms_reg <= 8'h0;
        blink_reg <= ~blink_reg;
      end else begin
        blink_ms_reg <= blink_ms_reg + 8'h1;
      end
    end
  end
  logic adj0;
  logic adj1;
  assign adj0 = (state_reg == ST_ADJ) && !chan_reg;
  assign adj1 = (state_reg == ST_ADJ) && chan_reg;
  logic ind0_reg;
  logic ind1_reg;
  // one blink phase serves both, as only one channel is adjusted at a time
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ind0_reg <= 1'b0;
      ind1_reg <= 1'b0;
      sig_reg <= 16'h0;
    end else begin
      ind0_reg <= adj0 ? blink_reg : closed[0];
      ind1_reg <= adj1 ? blink_reg : closed[1];
      // threshold replaces pressure only for the display window
      sig_reg <= (state_reg == ST_ADJ && show_ms_reg < 14'(SHOW_MS)) ? cur_thr : pressure;
    end
  end
  assign first_channel_indicator = ind0_reg;
  assign second_channel_indicator = ind1_reg;
  assign signal_out = sig_reg;

  // ***************************************************
  // register read port
  // ***************************************************
  logic [15:0] rd_reg;
  // idle cycles read zero, so a stale word is never taken for an answer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg <= 16'h0;
    end else if (reg_rd) begin
      if (reg_addr == REG_CTRL0 || reg_addr == REG_CTRL1) rd_reg <= {13'h0, cfg_reg[reg_addr[2]].mode,
        cfg_reg[reg_addr[2]].high_trip};
      else if (reg_addr == REG_THRESH0 || reg_addr == REG_THRESH1) rd_reg <= cfg_reg[reg_addr[2]].thresh;
      else if (reg_addr == REG_HYST0 || reg_addr == REG_HYST1) rd_reg <= cfg_reg[reg_addr[2]].hyst;
      else if (reg_addr == REG_FACTOR0 || reg_addr == REG_FACTOR1) rd_reg <= cfg_reg[reg_addr[2]].factor;
      else if (reg_addr == REG_STATUS) rd_reg <= {10'h0, state_reg, closed};
      else if (reg_addr == REG_ADDR) rd_reg <= {4'h0, addr_reg};
      else if (reg_addr == REG_USER) rd_reg <= user_reg;
      else rd_reg <= 16'h0;
    end else begin
      rd_reg <= 16'h0;
    end
  end
  assign reg_rdata = rd_reg;
endmodule : setpoint_switching
`default_nettype wire

/* setpoint_switching_properties.sv */
// Purpose: port-level assertions for the setpoint switching block
// Assumes: one mclk domain; no adjustment mode before a setpoint press
// Notes: helper flags track untouched config and address capture
`timescale 1ns/1ps
`default_nettype none
module setpoint_switching_properties
  import setpoint_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [15:0] pressure,
  input wire logic gauge_ok,
  input wire logic setpoint_button,
  input wire logic zero_button,
  input wire logic [3:0] address_switch_hundreds,
  input wire logic [3:0] address_switch_tens,
  input wire logic [3:0] address_switch_units,
  input wire logic [15:0] signal_out,
  input wire logic [1:0] contact_closed,
  input wire logic first_channel_indicator,
  input wire logic second_channel_indicator,
  input wire logic restore_pulse,
  input wire logic [11:0] explicit_address
);
  // ************************
  // helpers and properties
  // ************************
  logic sp_seen;
  logic fresh;
  logic [1:0] init_cnt;

  // adjustment needs a press first, so until then outputs must follow the run path
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sp_seen <= 1'b0;
      fresh <= 1'b1;
      init_cnt <= 2'h0;
    end else begin
      sp_seen <= sp_seen | setpoint_button;
      fresh <= fresh & ~reg_wr & ~setpoint_button;
      init_cnt <= (init_cnt == 2'h3) ? init_cnt : init_cnt + 2'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_wr_rd;
    reg_wr && reg_addr == REG_THRESH0 && !sp_seen ##1 !reg_wr ##1 reg_rd && reg_addr == REG_THRESH0;
  endsequence

  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  AST_RD_AFTER_WR: assert property (s_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("threshold read back differs from write");
  AST_DEFAULT_LOW: assert property (fresh && sample_valid && pressure < THRESH_DEFAULT
    |=> contact_closed == 2'b11)
    else $error("default channels not low trip");
  AST_CONTACT_CAUSE: assert property ($changed(contact_closed) |-> $past(sample_valid) || $past(reg_wr)
    || $past(reg_wr, 2) || $past(reg_wr, 3) || $past(restore_pulse) || $past(restore_pulse, 2)
    || $past(gauge_ok) != $past(gauge_ok, 2))
    else $error("contact changed without a cause");
  AST_INDICATORS: assert property (!sp_seen |=> {second_channel_indicator, first_channel_indicator}
    == $past(contact_closed))
    else $error("indicator does not follow contact");
  AST_ADDR_CAPTURE: assert property (init_cnt == 2'h1 |-> explicit_address ==
    12'h100 * $past(address_switch_hundreds) + 12'h010 * $past(address_switch_tens)
    + 12'h001 * $past(address_switch_units))
    else $error("address not formed from switches");
  AST_ADDR_HOLD: assert property (init_cnt >= 2'h2 |-> $stable(explicit_address))
    else $error("address changed after init");
  AST_RESTORE: assert property (restore_pulse |-> zero_button ##1 !restore_pulse)
    else $error("restore without held zero button or too long");
  AST_SIGNAL: assert property (!sp_seen && sample_valid |=> signal_out == $past(pressure))
    else $error("signal output does not show pressure");

  cover property (contact_closed[0] ##1 !contact_closed[0]);
  cover property ($rose(contact_closed[1]));
  cover property (s_wr_rd);
endmodule : setpoint_switching_properties

bind setpoint_switching setpoint_switching_properties i_props (
  .mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .pressure,
  .gauge_ok, .setpoint_button, .zero_button, .address_switch_hundreds, .address_switch_tens,
  .address_switch_units, .signal_out, .contact_closed, .first_channel_indicator,
  .second_channel_indicator, .restore_pulse, .explicit_address
);
`default_nettype wire

/* process_controller.sv */
// Purpose: process controller model reading contacts and signal output
// Assumes: polls both inputs every mclk
// Notes: listener only
`timescale 1ns/1ps
`default_nettype none
module process_controller
  import setpoint_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [1:0] contact_closed,
  input wire logic [15:0] signal_out,
  output logic [1:0] seen_contacts,
  output logic [15:0] seen_signal
);
  // ************************
  // polling
  // ************************
  // never drives the register port, so it cannot collide with the one register master
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seen_contacts <= 2'b00;
      seen_signal <= 16'h0000;
    end else begin
      seen_contacts <= contact_closed;
      seen_signal <= signal_out;
    end
  end
endmodule : process_controller
`default_nettype wire

/* pressure_setpoint_switching_tb_top.sv */
// Purpose: self-checking bench for setpoint switching
// Assumes: buttons idle; their ms-scale timing exceeds the run budget
// Notes: expectations come from package constants
`timescale 1ns/1ps
`default_nettype none
module pressure_setpoint_switching_tb_top;
  import setpoint_pkg::*;
  // ************************
  // bench
  // ************************
  logic mclk, arst_n, reg_wr, reg_rd, sample_valid, gauge_ok, setpoint_button, zero_button;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pressure, atmosphere, signal_out, seen_signal, amb_thr, hyst_1pc;
  logic [3:0] address_switch_hundreds, address_switch_tens, address_switch_units;
  logic [1:0] contact_closed, seen_contacts;
  logic first_channel_indicator, second_channel_indicator, status_blink_fast, restore_pulse;
  logic [11:0] explicit_address, exp_addr;
  logic [15:0] tbl_p [10];
  logic [1:0] tbl_c [10];
  int bad_count = 0;
  int n_checks = 0;

  setpoint_switching i_dut (
    .mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .pressure,
    .atmosphere, .gauge_ok, .setpoint_button, .zero_button, .address_switch_hundreds,
    .address_switch_tens, .address_switch_units, .signal_out, .contact_closed, .first_channel_indicator,
    .second_channel_indicator, .status_blink_fast, .restore_pulse, .explicit_address
  );
  process_controller i_ctrl (.mclk, .arst_n, .contact_closed, .signal_out, .seen_contacts, .seen_signal);

  task automatic check_value(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_value

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check_value(what, reg_rdata, exp);
  endtask : reg_read

  task automatic put_sample(input logic [15:0] p, input logic [1:0] exp);
    @(posedge mclk);
    pressure <= p;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    @(posedge mclk);
    #1;
    check_value("contacts", {14'h0, seen_contacts}, {14'h0, exp});
    check_value("leds", {14'h0, second_channel_indicator, first_channel_indicator}, {14'h0, exp});
    check_value("signal", seen_signal, p);
  endtask : put_sample

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  initial begin
    {arst_n, reg_wr, reg_rd, sample_valid, gauge_ok, setpoint_button, zero_button} = 7'h00;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    pressure = 16'h0000;
    atmosphere = 16'h4000;
    address_switch_hundreds = 4'h3;
    address_switch_tens = 4'ha;
    address_switch_units = 4'h5;
    exp_addr = 12'h100 * 12'h003 + 12'h010 * 12'h00a + 12'h001 * 12'h005;
    hyst_1pc = 16'(32'(FULL_SCALE) / 32'h0000_0064);
    repeat (6) @(posedge mclk);
    check_value("reset address", {4'h0, explicit_address}, {4'h0, ADDR_DEFAULT});
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_value("address", {4'h0, explicit_address}, {4'h0, exp_addr});
    {address_switch_hundreds, address_switch_tens, address_switch_units} <= 12'hddd;
    for (int ch = 0; ch < 2; ch++) begin
      reg_read(REG_CTRL0 + 5'(4 * ch), 16'h0000, "ctrl default");
      reg_read(REG_THRESH0 + 5'(4 * ch), THRESH_DEFAULT, "thresh default");
      reg_read(REG_HYST0 + 5'(4 * ch), hyst_1pc, "hyst default");
    end
    reg_read(REG_ADDR, {4'h0, exp_addr}, "address reg");
    put_sample(THRESH_DEFAULT - 16'h0001, 2'b11);
    reg_write(REG_CTRL1, 16'h0001);
    reg_write(REG_THRESH1, 16'h8000);
    reg_write(REG_HYST1, 16'h0100);
    reg_read(REG_CTRL1, 16'h0001, "ctrl1");
    tbl_p = '{THRESH_DEFAULT + 16'h0001, THRESH_DEFAULT + hyst_1pc, THRESH_DEFAULT + hyst_1pc + 16'h0001,
      THRESH_DEFAULT, THRESH_DEFAULT - 16'h0001, 16'h8001, 16'h7f00, 16'h7eff, 16'h8000, 16'h8001};
    tbl_c = '{2'b01, 2'b01, 2'b00, 2'b00, 2'b01, 2'b10, 2'b10, 2'b00, 2'b00, 2'b10};
    for (int i = 0; i < 10; i++) begin
      put_sample(tbl_p[i], tbl_c[i]);
    end
    reg_read(REG_STATUS, 16'h0012, "status");
    reg_write(REG_FACTOR0, 16'h0180);
    reg_write(REG_CTRL0, {13'h0000, MODE_AMBIENT, 1'b0});
    amb_thr = 16'((32'(atmosphere) * 32'h0000_0180) >> 8);
    put_sample(amb_thr - 16'h0001, 2'b01);
    put_sample(amb_thr + hyst_1pc, 2'b01);
    put_sample(amb_thr + hyst_1pc + 16'h0001, 2'b00);
    reg_write(REG_CTRL0, {13'h0000, MODE_AMBIENT, 1'b1});
    put_sample(amb_thr + 16'h0001, 2'b01);
    reg_read(REG_FACTOR0, 16'h0180, "factor0");
    reg_write(REG_CTRL1, {13'h0000, MODE_STATUS, 1'b0});
    for (int g = 1; g >= 0; g--) begin
      gauge_ok <= g[0];
      repeat (3) @(posedge mclk);
      #1;
      check_value("status contact", {15'h0, contact_closed[1]}, {15'h0, g[0]});
    end
    reg_write(REG_THRESH1, 16'hffff);
    reg_read(REG_THRESH1, 16'hffff, "thresh max");
    reg_write(REG_THRESH0, 16'h0000);
    reg_read(REG_THRESH0, 16'h0000, "thresh min");
    reg_write(5'h1f, 16'h1234);
    reg_read(5'h1f, 16'h0000, "unmapped");
    check_value("address held", {4'h0, explicit_address}, {4'h0, exp_addr});
    check_value("idle flags", {14'h0, restore_pulse, status_blink_fast}, 16'h0000);
    reg_write(REG_USER, 16'h5a5a);
    reg_read(REG_USER, 16'h5a5a, "user param");
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_value("address again", {4'h0, explicit_address}, 16'h0ddd);
    reg_read(REG_CTRL1, 16'h0000, "ctrl after reset");
    final_report();
  end
endmodule : pressure_setpoint_switching_tb_top
`default_nettype wire
